// ### scta_checker_properties.sv
module scta_checker
    import scta_pkg::*;
#(
    parameter int N_GROUP = 4,
    parameter int N_CHAN = 8
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [scta_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [N_CHAN-1:0] tx_frame_pulse,
    input wire logic [N_CHAN-1:0] framing_insert_active,
    input wire logic [7:0] framing_byte1_value,
    input wire logic [7:0] framing_byte2_value,
    input wire logic [7:0] tx_parity_byte_mask,
    input wire logic loopback_en,
    input wire logic parity_even,
    input wire logic scramble_en
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr;
    logic rd;
    logic [19:0] idx;
    assign wr = psel & penable & pready & pwrite & pstrb[0];
    assign rd = psel & penable & pready & !pwrite;
    assign idx = paddr[21:2];
    // Copies may sit one register behind the bank, so look two edges on
    ctrl_loop_a: assert property (wr && idx == IDX_CTRL |-> ##2 loopback_en == $past(pwdata[4], 2))
        else $error("loopback output not following control write");
    ctrl_parity_a: assert property (wr && idx == IDX_CTRL |-> ##2 parity_even == $past(pwdata[5], 2))
        else $error("parity output not following control write");
    ctrl_scramble_a: assert property (wr && idx == IDX_CTRL |-> ##2 scramble_en == $past(pwdata[6], 2))
        else $error("scramble output not following control write");
    byte1_copy_a: assert property (wr && idx == IDX_A1_VAL |-> ##2 framing_byte1_value == $past(pwdata[7:0], 2))
        else $error("first framing value not following write");
    byte2_copy_a: assert property (wr && idx == IDX_A2_VAL |-> ##2 framing_byte2_value == $past(pwdata[7:0], 2))
        else $error("second framing value not following write");
    parity_mask_a: assert property (wr && idx == IDX_B1_MASK |-> ##2 tx_parity_byte_mask == $past(pwdata[7:0], 2))
        else $error("parity mask not following write");
    alarm_upper_a: assert property (rd && (idx == IDX_ALARM_A || idx == IDX_ALARM_B) |-> prdata[31:4] == '0)
        else $error("alarm read shows unused bits");
    insert_start_a: assert property ($rose(framing_insert_active[0]) |-> $past(tx_frame_pulse[0]))
        else $error("insertion began without a frame pulse");
    refused_data_a: assert property (pready && pslverr |-> prdata == '0 ##1 !pready)
        else $error("refused access returned data or long answer");
endmodule : scta_checker

bind scta_core scta_checker #(.N_GROUP(N_GROUP), .N_CHAN(N_CHAN)) chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_frame_pulse(tx_frame_pulse),
    .framing_insert_active(framing_insert_active), .framing_byte1_value(framing_byte1_value),
    .framing_byte2_value(framing_byte2_value), .tx_parity_byte_mask(tx_parity_byte_mask),
    .loopback_en(loopback_en), .parity_even(parity_even), .scramble_en(scramble_en));

// ### scta_core.sv
// The APB interface to the registers was chosen for this implementation.
module scta_core
    import scta_pkg::*;
#(
    parameter int N_GROUP = 4,
    parameter int N_CHAN = 8
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [scta_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [N_CHAN-1:0] tx_frame_pulse,
    input wire logic [N_GROUP-1:0] group_a_alarm_raw,
    input wire logic [N_GROUP-1:0] group_b_alarm_raw,
    output logic [N_CHAN-1:0] framing_insert_active,
    output logic [7:0] framing_byte1_value,
    output logic [7:0] framing_byte2_value,
    output logic [7:0] tx_parity_byte_mask,
    output logic loopback_en,
    output logic parity_even,
    output logic scramble_en,
    output logic irq
);
    import scta_pkg::*;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0] ctrl_q;
    logic [7:0] a1_val_q;
    logic [7:0] a2_val_q;
    logic [7:0] b1_mask_q;
    logic [N_GROUP-1:0] alarm_en_q;
    logic [N_GROUP-1:0] alarm_a_q;
    logic [N_GROUP-1:0] alarm_b_q;
    logic [IRQ_W-1:0] irq_status_q;
    logic [IRQ_W-1:0] irq_mask_q;
    logic [N_CHAN-1:0] insert_q;
    logic [CTRL_COUNT_W-1:0] remain_q [N_CHAN];
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic irq_q;

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    logic [19:0] idx;
    logic access;
    logic wr_en;
    logic [7:0] wbyte;
    logic mapped;
    logic [31:0] rdata_d;
    logic [N_CHAN-1:0] busy;
    logic [N_CHAN-1:0] arm;
    logic [N_CHAN-1:0] done_evt;
    logic [2*N_GROUP-1:0] alarm_rise;

    assign idx = paddr[ADDR_W-1:2];
    // One wait state: pready rises on the second access cycle
    assign access = psel && penable && !pready_q;
    assign wr_en = psel && penable && pready_q && pwrite && !pslverr_q;
    // Lane 0 carries byte register data; the interrupt registers take pwdata[15:0] whatever pstrb holds
    assign wbyte = pstrb[0] ? pwdata[7:0] : 8'h00;

    always_comb
    begin
        for (int i = 0; i < N_CHAN; i++)
        begin
            busy[i] = (remain_q[i] != '0) || insert_q[i];
        end
    end

    always_comb
    begin
        mapped = 1'b1;
        rdata_d = 32'h0000_0000;
        if (idx == IDX_CTRL)
        begin
            rdata_d[7:0] = ctrl_q;
        end
        else if (idx == IDX_A1_VAL)
        begin
            rdata_d[7:0] = a1_val_q;
        end
        else if (idx == IDX_A2_VAL)
        begin
            rdata_d[7:0] = a2_val_q;
        end
        else if (idx == IDX_B1_MASK)
        begin
            rdata_d[7:0] = b1_mask_q;
        end
        else if (idx == IDX_ALARM_A)
        begin
            rdata_d[N_GROUP-1:0] = alarm_a_q;
        end
        else if (idx == IDX_ALARM_EN)
        begin
            rdata_d[N_GROUP-1:0] = alarm_en_q;
        end
        else if (idx == IDX_ALARM_B)
        begin
            rdata_d[N_GROUP-1:0] = alarm_b_q;
        end
        else if (idx == IDX_INSERT_CMD)
        begin
            rdata_d[N_CHAN-1:0] = busy;
        end
        else if (idx == IDX_IRQ_STATUS)
        begin
            rdata_d[IRQ_W-1:0] = irq_status_q;
        end
        else if (idx == IDX_IRQ_MASK)
        begin
            rdata_d[IRQ_W-1:0] = irq_mask_q;
        end
        else
        begin
            mapped = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            pready_q <= access;
            if (access)
            begin
                pslverr_q <= !mapped;
                prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
            end
            else
            begin
                pslverr_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Software written registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= CTRL_RESET;
            a1_val_q <= BYTE_RESET;
            a2_val_q <= BYTE_RESET;
            b1_mask_q <= BYTE_RESET;
            alarm_en_q <= ALARM_EN_RESET;
            irq_mask_q <= IRQ_RESET;
        end
        else if (wr_en)
        begin
            if (idx == IDX_CTRL)
            begin
                ctrl_q <= wbyte & CTRL_WMASK;
            end
            else if (idx == IDX_A1_VAL)
            begin
                a1_val_q <= wbyte;
            end
            else if (idx == IDX_A2_VAL)
            begin
                a2_val_q <= wbyte;
            end
            else if (idx == IDX_B1_MASK)
            begin
                b1_mask_q <= wbyte;
            end
            else if (idx == IDX_ALARM_EN)
            begin
                alarm_en_q <= wbyte[N_GROUP-1:0];
            end
            else if (idx == IDX_IRQ_MASK)
            begin
                irq_mask_q <= pwdata[IRQ_W-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Framing byte error insertion
    // ----------------------------------------------------------------
    // A command written while a channel is busy is dropped, so a running
    // burst is never stretched or cut short by software.
    assign arm = (wr_en && idx == IDX_INSERT_CMD) ? (pwdata[N_CHAN-1:0] & ~busy) : '0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            insert_q <= '0;
            done_evt <= '0;
            for (int i = 0; i < N_CHAN; i++)
            begin
                remain_q[i] <= '0;
            end
        end
        else
        begin
            for (int i = 0; i < N_CHAN; i++)
            begin
                done_evt[i] <= 1'b0;
                if (arm[i])
                begin
                    remain_q[i] <= ctrl_q[CTRL_COUNT_LSB +: CTRL_COUNT_W];
                end
                else if (tx_frame_pulse[i])
                begin
                    if (remain_q[i] != '0)
                    begin
                        insert_q[i] <= 1'b1;
                        remain_q[i] <= remain_q[i] - 1'b1;
                    end
                    else
                    begin
                        insert_q[i] <= 1'b0;
                        done_evt[i] <= insert_q[i];
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Consolidated alarms
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            alarm_a_q <= '0;
            alarm_b_q <= '0;
        end
        else
        begin
            alarm_a_q <= group_a_alarm_raw & alarm_en_q;
            alarm_b_q <= group_b_alarm_raw & alarm_en_q;
        end
    end

    assign alarm_rise = {group_b_alarm_raw & alarm_en_q & ~alarm_b_q,
                         group_a_alarm_raw & alarm_en_q & ~alarm_a_q};

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    // A new event in the clearing cycle keeps its bit set
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_status_q <= IRQ_RESET;
            irq_q <= 1'b0;
        end
        else
        begin
            irq_status_q <= (irq_status_q
                             & ~((wr_en && idx == IDX_IRQ_STATUS) ? pwdata[IRQ_W-1:0] : '0))
                            | {done_evt, alarm_rise};
            irq_q <= |(irq_status_q & irq_mask_q);
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign framing_insert_active = insert_q;
    assign framing_byte1_value = a1_val_q;
    assign framing_byte2_value = a2_val_q;
    assign tx_parity_byte_mask = b1_mask_q;
    assign loopback_en = ctrl_q[CTRL_LOOP_BIT];
    assign parity_even = ctrl_q[CTRL_PARITY_BIT];
    assign scramble_en = ctrl_q[CTRL_SCRAMBLE_BIT];
    assign irq = irq_q;

endmodule : scta_core

// ### scta_pkg.sv
//
// Behaviour
// - While a channel's framing-error insert command is armed, that channel is told to send the programmed A1 and A2 error values in place of its framing bytes.
// - The number of consecutive corrupted frames is the four-bit count in bits 3 to 0 of the control register, bit 3 most significant.
// - Control bit 4 at 1 loops received data back through the parallel path to the transmitter; at 0 there is no loopback.
// - Control bit 5 selects odd parallel-bus parity at 0 and even at 1, and resets to even.
// - Control bit 6 at 1 enables receive descrambling and transmit scrambling, at 0 neither, and resets to 1.
// - An eight-bit register holds the A1 substitute byte and resets to zero.
// - An eight-bit register holds the A2 substitute byte and resets to zero.
// - Each 1 in the eight-bit transmit mask inverts the matching bit of the sent B1 byte; a 0 leaves it alone.
// - A read-only register shows one consolidated alarm bit per group-A channel in bits 3 to 0, 1 meaning alarm, bits 7 to 4 unused.
// - Bit n of the alarm enable register enables the consolidated alarm of channel n in both groups, all bits resetting to 0.
// - A second read-only register shows the four group-B consolidated alarms in bits 3 to 0, gated by the shared enables.
package scta_pkg;

    // ----------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [19:0] IDX_CTRL = 20'h3000c;
    localparam logic [19:0] IDX_A1_VAL = 20'h3000d;
    localparam logic [19:0] IDX_A2_VAL = 20'h3000e;
    localparam logic [19:0] IDX_B1_MASK = 20'h3000f;
    localparam logic [19:0] IDX_ALARM_A = 20'h30010;
    localparam logic [19:0] IDX_ALARM_EN = 20'h30011;
    localparam logic [19:0] IDX_ALARM_B = 20'h30014;
    localparam logic [19:0] IDX_INSERT_CMD = 20'h30020;
    localparam logic [19:0] IDX_IRQ_STATUS = 20'h30021;
    localparam logic [19:0] IDX_IRQ_MASK = 20'h30022;

    localparam int ADDR_W = 22;

    // ----------------------------------------------------------------
    // Control register fields
    // ----------------------------------------------------------------
    localparam int CTRL_COUNT_LSB = 0;
    localparam int CTRL_COUNT_W = 4;
    localparam int CTRL_LOOP_BIT = 4;
    localparam int CTRL_PARITY_BIT = 5;
    localparam int CTRL_SCRAMBLE_BIT = 6;
    localparam logic [7:0] CTRL_WMASK = 8'h7f;
    localparam logic [7:0] CTRL_RESET = 8'h60;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [3:0] ALARM_EN_RESET = 4'h0;

    // ----------------------------------------------------------------
    // Interrupt layout: alarm rises in 7:0, insert done in 15:8
    // ----------------------------------------------------------------
    localparam int IRQ_W = 16;
    localparam int IRQ_DONE_LSB = 8;
    localparam logic [15:0] IRQ_RESET = 16'h0000;

endpackage : scta_pkg

// ### tb_sonet_core_test_alarm_ctrl.sv
module tb_sonet_core_test_alarm_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    import scta_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic loopback_en, parity_even, scramble_en, irq;
    logic [21:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [3:0] pstrb, raw_a, raw_b;
    logic [7:0] tx_frame_pulse, framing_insert_active, b1, b2, msk;
    int num_errors = 0;
    int checked = 0;

    scta_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tx_frame_pulse(tx_frame_pulse),
        .group_a_alarm_raw(raw_a), .group_b_alarm_raw(raw_b),
        .framing_insert_active(framing_insert_active), .framing_byte1_value(b1),
        .framing_byte2_value(b2), .tx_parity_byte_mask(msk), .loopback_en(loopback_en),
        .parity_even(parity_even), .scramble_en(scramble_en), .irq(irq));

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            $display("mismatch %s expected %h seen %h", name, exp, seen);
            num_errors++;
        end
    endtask : check

    // Master holds the request until pready is sampled; bounded so a dead slave ends the run
    task automatic apb(input logic w, input logic [19:0] idx, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
        begin
            num_errors++;
            conclude();
        end
    endtask : apb

    task automatic rc(input logic [19:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        check("register read", rdata, exp);
    endtask : rc

    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
    endtask : settle

    initial
    begin
        presetn = 1'b0;
        {psel, penable, pwrite} = 3'h0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'hf;
        tx_frame_pulse = '0;
        raw_a = '0;
        raw_b = '0;
        settle(10);
        presetn <= 1'b1;
        // ------------------------------------------------------------
        // Reset values and control bits
        // ------------------------------------------------------------
        rc(IDX_CTRL, 32'h60);
        rc(IDX_A1_VAL, 32'h0);
        rc(IDX_A2_VAL, 32'h0);
        rc(IDX_B1_MASK, 32'h0);
        rc(IDX_ALARM_EN, 32'h0);
        check("ctrl outputs", {parity_even, scramble_en, loopback_en}, 32'h6);
        apb(1'b1, IDX_CTRL, 32'hffff_ffff);
        rc(IDX_CTRL, 32'h7f);
        check("loopback", loopback_en, 32'h1);
        apb(1'b1, IDX_CTRL, 32'h13);
        rc(IDX_CTRL, 32'h13);
        check("ctrl outputs", {parity_even, scramble_en, loopback_en}, 32'h1);
        // ------------------------------------------------------------
        // Substitute bytes and parity mask
        // ------------------------------------------------------------
        apb(1'b1, IDX_A1_VAL, 32'h1234_56a5);
        apb(1'b1, IDX_A2_VAL, 32'h5a);
        apb(1'b1, IDX_B1_MASK, 32'h81);
        rc(IDX_A1_VAL, 32'ha5);
        rc(IDX_A2_VAL, 32'h5a);
        rc(IDX_B1_MASK, 32'h81);
        check("byte outputs", {b1, b2, msk}, 32'ha55a81);
        // Lane 0 strobe low writes zero to a byte register
        pstrb <= 4'he;
        apb(1'b1, IDX_B1_MASK, 32'hff);
        pstrb <= 4'hf;
        rc(IDX_B1_MASK, 32'h0);
        // ------------------------------------------------------------
        // Alarms, enables and interrupt
        // ------------------------------------------------------------
        raw_a <= 4'hf;
        raw_b <= 4'h5;
        apb(1'b1, IDX_ALARM_EN, 32'hf6);
        rc(IDX_ALARM_EN, 32'h06);
        settle(3);
        apb(1'b1, IDX_ALARM_A, 32'hff);
        rc(IDX_ALARM_A, 32'h6);
        rc(IDX_ALARM_B, 32'h4);
        rc(IDX_IRQ_STATUS, 32'h46);
        check("irq masked", irq, 32'h0);
        apb(1'b1, IDX_IRQ_MASK, 32'h4);
        settle(2);
        check("irq raised", irq, 32'h1);
        apb(1'b1, IDX_IRQ_STATUS, 32'h4);
        settle(2);
        check("irq cleared", irq, 32'h0);
        rc(IDX_IRQ_STATUS, 32'h42);
        // ------------------------------------------------------------
        // Framing error insertion over three frames
        // ------------------------------------------------------------
        apb(1'b1, IDX_INSERT_CMD, 32'h1);
        rc(IDX_INSERT_CMD, 32'h1);
        // A second command while busy must not restart the burst
        apb(1'b1, IDX_INSERT_CMD, 32'h1);
        for (int k = 0; k < 4; k++)
        begin
            @(posedge pclk);
            tx_frame_pulse <= 8'h01;
            @(posedge pclk);
            tx_frame_pulse <= 8'h00;
            settle(2);
            check("insert active", framing_insert_active, (k < 3) ? 32'h1 : 32'h0);
        end
        rc(IDX_IRQ_STATUS, 32'h142);
        // ------------------------------------------------------------
        // Zero count corrupts no frame
        // ------------------------------------------------------------
        apb(1'b1, IDX_CTRL, 32'h10);
        apb(1'b1, IDX_INSERT_CMD, 32'h2);
        rc(IDX_INSERT_CMD, 32'h0);
        @(posedge pclk);
        tx_frame_pulse <= 8'h02;
        @(posedge pclk);
        tx_frame_pulse <= 8'h00;
        settle(2);
        check("zero count", framing_insert_active, 32'h0);
        rc(IDX_IRQ_STATUS, 32'h142);
        // ------------------------------------------------------------
        // Unmapped address
        // ------------------------------------------------------------
        apb(1'b0, 20'h30015, 32'h0);
        check("refused", err, 32'h1);
        check("refused data", rdata, 32'h0);
        conclude();
    end
endmodule : tb_sonet_core_test_alarm_ctrl
